// file: block_protection_command_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module block_protection_command_decoder_tb_top import guard_cmd_pkg::*;;
	// ------------------------------------------------------------
	// Bench signals.
	// ------------------------------------------------------------
	localparam logic [7:0] SELS [6] = '{SEL_LOCKREG, SEL_PASSWORD,
		SEL_PERSIST, SEL_FREEZE, SEL_VOLATILE, SEL_EXTBLK};
	localparam set_t SETS [6] = '{SET_LOCKREG, SET_PASSWORD,
		SET_PERSIST, SET_FREEZE, SET_VOLATILE, SET_EXTBLK};
	logic        clk, rst_n, cmd_valid, ready, done, err, uwait;
	logic        dq_oe, ce_n, oe_n, we_n, byte_n;
	op_t         cmd;
	set_t        set, m_set;
	logic [23:0] addr, faddr;
	logic [7:0]  data, rdata, dq_out, dq_m, dq_bus, gb, ob, bad, lv;
	logic [63:0] pw;
	logic [15:0] wcnt, lo;
	int          errors, tests_run, seed, overlap, kk, j;
	assign dq_bus = dq_oe ? dq_out : dq_m;

	guard_cmd_host i_dut (.i_clk(clk), .i_rst_n(rst_n),
		.i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_addr(addr), .i_data(data),
		.i_password(pw), .o_cmd_ready(ready), .o_cmd_done(done),
		.o_cmd_err(err), .o_rd_data(rdata), .o_set(set),
		.o_unlock_wait(uwait), .o_flash_addr(faddr), .o_dq_out(dq_out),
		.o_dq_oe(dq_oe), .i_dq_in(dq_bus), .o_ce_n(ce_n), .o_oe_n(oe_n),
		.o_we_n(we_n), .o_byte_n(byte_n));
	flash_guard_model i_model (.i_clk(clk), .i_rst_n(rst_n),
		.i_addr(faddr), .i_dq(dq_bus), .i_ce_n(ce_n), .i_oe_n(oe_n),
		.i_we_n(we_n), .o_dq(dq_m), .o_set(m_set), .o_wr_cnt(wcnt));

	// Clock and a watchdog sized well beyond the expected run.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#200000;
		errors++;
		complete_run();
	end

	// Read and write strobes must never overlap, nor a read meet our drive.
	// Looked at mid-cycle, where the registered pins have settled.
	always @(negedge clk) begin
		if (!oe_n && (!we_n || dq_oe)) overlap++;
	end

	// ------------------------------------------------------------
	// Tasks.
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [63:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One command; the answer is sampled at falling edges, where it is settled.
	task automatic run(input op_t op, input logic [23:0] a,
		input logic [7:0] d, input logic rej, input int nwr);
		int          n;
		logic [15:0] w0;
		w0 = wcnt;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= op;
		addr <= a;
		data <= d;
		@(posedge clk);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (done !== 1'b1 && err !== 1'b1 && n < 400);
		chk("answered", n < 400, 1'b1);
		chk("refused", err, rej);
		chk("write cycles", wcnt - w0, rej ? 0 : nwr);
	endtask : run

	task automatic rd(input logic [23:0] a, input logic [7:0] e);
		run(OP_READ, a, 8'h00, 1'b0, 0);
		chk("read data", rdata, e);
	endtask : rd

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------
	initial begin
		seed = 32'h779f;
		errors = 0;
		tests_run = 0;
		overlap = 0;
		cmd_valid = 1'b0;
		cmd = OP_ENTER;
		addr = 24'h000000;
		data = 8'h00;
		pw = {$random(seed), $random(seed)};
		lo = 16'($random(seed));
		gb = 8'($random(seed));
		ob = gb ^ 8'h01;
		rst_n = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("idle set", set, SET_NONE);
		chk("pins", {ready, ce_n, oe_n, we_n, byte_n}, 5'h1E);
		$display("Test reset done");
		// Refusals with no set active, then every selector in and out.
		run(OP_EXIT, 24'h0, 8'h00, 1'b1, 0);
		run(OP_PGM, 24'h0, 8'h00, 1'b1, 0);
		do bad = 8'($random(seed)); while (bad inside {SELS});
		run(OP_ENTER, ENTRY_ADDR_A, bad, 1'b1, 0);
		for (int k = 0; k < 6; k++) begin
			run(OP_ENTER, 24'h0, SELS[k], 1'b0, 3);
			chk("set", set, SETS[k]);
			chk("device set", m_set, SETS[k]);
			run(OP_ENTER, 24'h0, SELS[k], 1'b1, 0);
			run(OP_EXIT, 24'h0, 8'h00, 1'b0, k == 5 ? 4 : 2);
			chk("device left", m_set, SET_NONE);
		end
		$display("Test sets done");
		// Persistent guard, volatile override, freeze and failed clear.
		run(OP_ENTER, 24'h0, SEL_PERSIST, 1'b0, 3);
		run(OP_PGM, {gb, lo}, 8'h00, 1'b0, 2);
		rd({gb, ~lo}, 8'h00);
		rd({ob, lo}, 8'h01);
		run(OP_EXIT, 24'h0, 8'h00, 1'b0, 2);
		run(OP_ENTER, 24'h0, SEL_VOLATILE, 1'b0, 3);
		run(OP_PGM, {gb, lo}, 8'h01, 1'b0, 2);
		rd({gb, lo}, 8'h00);
		run(OP_PGM, {ob, lo}, 8'h00, 1'b0, 2);
		rd({ob, lo}, 8'h00);
		run(OP_PGM, {ob, lo}, 8'h01, 1'b0, 2);
		rd({ob, lo}, 8'h01);
		run(OP_EXIT, 24'h0, 8'h00, 1'b0, 2);
		run(OP_ENTER, 24'h0, SEL_FREEZE, 1'b0, 3);
		rd({lo, 8'h00}, 8'h01);
		run(OP_CLEAR, 24'h0, 8'h00, 1'b1, 0);
		chk("set kept", set, SET_FREEZE);
		run(OP_PGM, {lo, 8'h00}, 8'h00, 1'b0, 2);
		rd({8'h00, lo}, 8'h00);
		run(OP_EXIT, 24'h0, 8'h00, 1'b0, 2);
		run(OP_ENTER, 24'h0, SEL_PERSIST, 1'b0, 3);
		run(OP_CLEAR, 24'h0, 8'h00, 1'b0, 2);
		rd({gb, lo}, 8'h00);
		run(OP_PGM, {ob, lo}, 8'h00, 1'b0, 2);
		rd({ob, lo}, 8'h01);
		run(OP_EXIT, 24'h0, 8'h00, 1'b0, 2);
		$display("Test guards done");
		// Password bytes in scrambled order, read back, then unlock.
		run(OP_ENTER, 24'h0, SEL_PASSWORD, 1'b0, 3);
		kk = $random(seed);
		for (int i = 0; i < 8; i++) begin
			j = (i ^ kk) & 7;
			run(OP_PGM, {lo, 5'h1F, j[2:0]}, pw[8*j +: 8], 1'b0, 2);
		end
		for (int i = 7; i >= 0; i--) begin
			rd({lo, 5'h00, i[2:0]}, pw[8*i +: 8]);
		end
		run(OP_UNLOCK, 24'h0, 8'h00, 1'b0, 11);
		chk("gap", uwait, 1'b1);
		run(OP_UNLOCK, 24'h0, 8'h00, 1'b1, 0);
		run(OP_EXIT, 24'h0, 8'h00, 1'b0, 2);
		run(OP_ENTER, 24'h0, SEL_PERSIST, 1'b0, 3);
		run(OP_CLEAR, 24'h0, 8'h00, 1'b0, 2);
		rd({gb, lo}, 8'h01);
		run(OP_EXIT, 24'h0, 8'h00, 1'b0, 2);
		$display("Test password done");
		// Lock register, then locked password reads show all ones.
		lv = 8'($random(seed)) & 8'hFB;
		run(OP_ENTER, 24'h0, SEL_LOCKREG, 1'b0, 3);
		run(OP_PGM, {lo, 8'h00}, lv, 1'b0, 2);
		rd({8'h00, lo}, lv);
		run(OP_EXIT, 24'h0, 8'h00, 1'b0, 2);
		run(OP_ENTER, 24'h0, SEL_PASSWORD, 1'b0, 3);
		rd(24'h000003, 8'hFF);
		run(OP_EXIT, 24'h0, 8'h00, 1'b0, 2);
		chk("strobe overlap", overlap, 0);
		$display("Test lock done");
		complete_run();
	end
endmodule : block_protection_command_decoder_tb_top
`default_nettype wire

// file: flash_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle
	import guard_cmd_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_start,
	input  wire bus_step_t         i_step,
	input  wire logic [DATA_W-1:0] i_dq_in,
	output logic                   o_done,
	output logic      [DATA_W-1:0] o_rdata,
	output logic      [ADDR_W-1:0] o_addr,
	output logic      [DATA_W-1:0] o_dq_out,
	output logic                   o_dq_oe,
	output logic                   o_ce_n,
	output logic                   o_oe_n,
	output logic                   o_we_n
);

	// -------------------------------------------------------------
	// One asynchronous bus cycle: setup, strobe, hold.
	// -------------------------------------------------------------
	typedef enum logic [1:0] {
		C_IDLE   = 2'b00,
		C_SETUP  = 2'b01,
		C_STROBE = 2'b10,
		C_HOLD   = 2'b11
	} cyc_t;

	cyc_t       state_r;
	logic       rd_r;
	logic [3:0] cnt_r;

	// The strobe is held for the full access time before the read is
	// sampled, so slow parts simply cost a few more cycles.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r  <= C_IDLE;
			rd_r     <= 1'b0;
			cnt_r    <= 4'h0;
			o_addr   <= '0;
			o_dq_out <= '0;
			o_dq_oe  <= 1'b0;
			o_ce_n   <= 1'b1;
			o_oe_n   <= 1'b1;
			o_we_n   <= 1'b1;
			o_rdata  <= '0;
		end else begin
			unique case (state_r)
				C_IDLE: begin
					if (i_start) begin
						o_addr   <= i_step.addr;
						o_dq_out <= i_step.data;
						o_dq_oe  <= !i_step.rd;
						rd_r     <= i_step.rd;
						o_ce_n   <= 1'b0;
						state_r  <= C_SETUP;
					end
				end
				C_SETUP: begin
					o_we_n  <= rd_r;
					o_oe_n  <= !rd_r;
					cnt_r   <= rd_r ? 4'(OE_LOW_CYC - 1) : 4'(WE_LOW_CYC - 1);
					state_r <= C_STROBE;
				end
				C_STROBE: begin
					if (cnt_r == 4'h0) begin
						o_we_n  <= 1'b1;
						o_oe_n  <= 1'b1;
						state_r <= C_HOLD;
						if (rd_r) begin
							o_rdata <= i_dq_in;
						end
					end else begin
						cnt_r <= cnt_r - 4'h1;
					end
				end
				C_HOLD: begin
					o_ce_n  <= 1'b1;
					o_dq_oe <= 1'b0;
					state_r <= C_IDLE;
				end
			endcase
		end
	end

	// Completion pulse, one cycle, in the hold cycle's wake.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_done <= 1'b0;
		end else begin
			o_done <= (state_r == C_HOLD);
		end
	end

	// -------------------------------------------------------------
	// Checks.
	// -------------------------------------------------------------
	chk_write_pulse_width: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		$fell(o_we_n) |-> (!o_we_n && o_dq_oe && !o_ce_n) [*5])
		else $error("Write strobe shorter than its least width.");

	chk_read_no_drive: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		!o_oe_n |-> !o_dq_oe && o_we_n)
		else $error("Data bus driven during a read cycle.");

endmodule : flash_bus_cycle
`default_nettype wire

// file: flash_guard_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_guard_model
	import guard_cmd_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_dq,
	input  wire logic              i_ce_n,
	input  wire logic              i_oe_n,
	input  wire logic              i_we_n,
	output logic      [DATA_W-1:0] o_dq,
	output set_t                   o_set,
	output logic      [15:0]       o_wr_cnt
);
	// ------------------------------------------------------------
	// Device state.
	// ------------------------------------------------------------
	logic [7:0]        h1, h2, lockreg_r, unl_r, rdv, blk;
	logic [ADDR_W-1:0] a1, a2;
	logic [63:0]       pw_r, try_r;
	logic [255:0]      prot_r, vol_r;
	logic              freeze_r, we_q;
	assign blk = i_addr[23:16];

	// Writes are decoded as the write strobe rises, from a short history.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			we_q <= 1'b1;
			h1 <= 8'hFF;
			h2 <= 8'hFF;
			lockreg_r <= 8'hFF;
			pw_r <= '1;
			prot_r <= '0;
			vol_r <= '0;
			freeze_r <= 1'b1;
			unl_r <= 8'h00;
			o_set <= SET_NONE;
			o_wr_cnt <= 16'h0000;
		end else begin
			we_q <= i_we_n;
			if (!we_q && i_we_n && !i_ce_n) begin
				o_wr_cnt <= o_wr_cnt + 16'h0001;
				h1 <= i_dq;
				h2 <= h1;
				a1 <= i_addr;
				a2 <= a1;
				if (unl_r != 8'h00) begin
					unl_r <= unl_r + 8'h01;
					if (unl_r >= 8'h02 && unl_r <= 8'h09) begin
						try_r[i_addr[2:0]*8 +: 8] <= i_dq;
					end
					if (unl_r == 8'h01 && i_dq != PW_UNLOCK_D2) begin
						unl_r <= 8'h00;
					end
					if (unl_r == 8'h0A) begin
						unl_r <= 8'h00;
						if (i_dq == PW_UNLOCK_END && try_r == pw_r) begin
							freeze_r <= 1'b1;
						end
					end
				end else if (o_set == SET_NONE) begin
					if (h2 == UNLOCK_D1 && a2 == ENTRY_ADDR_A && h1 == UNLOCK_D2
						&& a1 == ENTRY_ADDR_B && i_addr == ENTRY_ADDR_A) begin
						case (i_dq)
						SEL_LOCKREG: o_set <= SET_LOCKREG;
						SEL_PASSWORD: o_set <= SET_PASSWORD;
						SEL_PERSIST: o_set <= SET_PERSIST;
						SEL_FREEZE: o_set <= SET_FREEZE;
						SEL_VOLATILE: o_set <= SET_VOLATILE;
						SEL_EXTBLK: o_set <= SET_EXTBLK;
						default: ;
						endcase
					end
				end else if (h1 == EXIT_D1 && i_dq == EXIT_D2) begin
					o_set <= SET_NONE;
				end else if (h1 == PGM_PREFIX) begin
					h1 <= 8'hFF;
					case (o_set)
					SET_LOCKREG: lockreg_r <= lockreg_r & i_dq;
					SET_PASSWORD: pw_r[i_addr[2:0]*8 +: 8] <= i_dq;
					SET_PERSIST: prot_r[blk] <= freeze_r | prot_r[blk];
					SET_FREEZE: freeze_r <= 1'b0;
					SET_VOLATILE: vol_r[blk] <= (i_dq == 8'h00);
					default: ;
					endcase
				end else if (h1 == CLEAR_D1 && i_dq == CLEAR_D2
					&& o_set == SET_PERSIST) begin
					if (freeze_r) begin
						prot_r <= '0;
					end
				end else if (o_set == SET_PASSWORD && i_dq == PW_UNLOCK_D1) begin
					unl_r <= 8'h01;
				end
			end
		end
	end

	// Status reads put the guard on bit 0, zero meaning protected.
	always_comb begin
		case (o_set)
		SET_LOCKREG: rdv = lockreg_r;
		SET_PASSWORD: rdv = lockreg_r[2] ? pw_r[i_addr[2:0]*8 +: 8] : 8'hFF;
		SET_PERSIST: rdv = {7'h00, ~prot_r[blk]};
		SET_FREEZE: rdv = {7'h00, freeze_r};
		SET_VOLATILE: rdv = {7'h00, ~(vol_r[blk] | prot_r[blk])};
		default: rdv = i_addr[7:0] ^ 8'h5A;
		endcase
	end

	// A released bus toggles, so a late sample never sees stale data.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_dq <= 8'h00;
		end else begin
			o_dq <= (!i_ce_n && !i_oe_n) ? rdv : ~o_dq;
		end
	end
endmodule : flash_guard_model
`default_nettype wire

// file: guard_cmd_host.sv
// Notes on behaviour
// - Entry is AA@AAA, 55@555, selector@AAA.
// - Enter a set before any protection operation.
// - Exit the set before expecting array reads.
// - Lock register: A0 plus data; single read.
// - Password program stores one byte at index.
// - Unlock: 25, 03, eight bytes, 29.
// - Guard or freeze set by A0 then 00.
// - Only data cycles of reads are reads.
// - Unlock commands spaced by at least 1 us.
`timescale 1ns/1ps
`default_nettype none
module guard_cmd_host
	import guard_cmd_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_cmd_valid,
	input  wire op_t               i_cmd,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_data,
	input  wire logic [63:0]       i_password,
	output logic                   o_cmd_ready,
	output logic                   o_cmd_done,
	output logic                   o_cmd_err,
	output logic      [DATA_W-1:0] o_rd_data,
	output set_t                   o_set,
	output logic                   o_unlock_wait,
	output logic      [ADDR_W-1:0] o_flash_addr,
	output logic      [DATA_W-1:0] o_dq_out,
	output logic                   o_dq_oe,
	input  wire logic [DATA_W-1:0] i_dq_in,
	output logic                   o_ce_n,
	output logic                   o_oe_n,
	output logic                   o_we_n,
	output logic                   o_byte_n
);
	// -------------------------------------------------------------
	// Sequencer state.
	// -------------------------------------------------------------
	typedef enum logic [1:0] {
		S_IDLE  = 2'b00,
		S_ISSUE = 2'b01,
		S_WAIT  = 2'b10
	} seq_t;
	seq_t        state_r;
	op_t         op_r;
	set_t        set_r;
	logic [3:0]  idx_r;
	logic [ADDR_W-1:0] addr_r;
	logic [DATA_W-1:0] data_r;
	logic [63:0] pw_r;
	logic [6:0]  gap_r;
	bus_step_t   step;
	logic [3:0]  n_steps;
	logic        legal, accept, bus_done, start, last;
	logic [DATA_W-1:0] bus_rdata;
	logic [2:0]  pw_sel;
	set_t        sel_set;
	// Byte-wide organisation is the only mode this controller speaks.
	assign o_byte_n      = 1'b0;
	assign o_cmd_ready   = (state_r == S_IDLE);
	assign o_set         = set_r;
	assign o_unlock_wait = (gap_r != 7'h0);
	assign start         = (state_r == S_ISSUE);
	assign accept        = i_cmd_valid && o_cmd_ready && legal;
	assign last          = (idx_r == n_steps - 4'h1);
	assign pw_sel        = 3'(idx_r - UNLOCK_PW_FIRST);
	// Decode the request's selector while idle, the latched one while busy.
	always_comb begin
		unique case (o_cmd_ready ? i_data : data_r)
			SEL_LOCKREG:  sel_set = SET_LOCKREG;
			SEL_PASSWORD: sel_set = SET_PASSWORD;
			SEL_PERSIST:  sel_set = SET_PERSIST;
			SEL_FREEZE:   sel_set = SET_FREEZE;
			SEL_VOLATILE: sel_set = SET_VOLATILE;
			SEL_EXTBLK:   sel_set = SET_EXTBLK;
			default:      sel_set = SET_NONE;
		endcase
	end
	// Refuse what the device would discard silently, rather than send it.
	always_comb begin
		unique case (i_cmd)
			OP_ENTER:  legal = (set_r == SET_NONE) &&
				(sel_set != SET_NONE);
			OP_EXIT:   legal = (set_r != SET_NONE);
			OP_PGM, OP_READ: legal = (set_r != SET_NONE) &&
				(set_r != SET_EXTBLK);
			OP_CLEAR:  legal = (set_r == SET_PERSIST);
			OP_UNLOCK: legal = (set_r == SET_PASSWORD) &&
				(gap_r == 7'h0);
			default:   legal = 1'b0;
		endcase
	end
	// -------------------------------------------------------------
	// Cycle table: address, data and direction of each bus cycle.
	// -------------------------------------------------------------
	always_comb begin
		step    = '0;
		n_steps = LEN_READ;
		unique case (op_r)
			OP_ENTER: begin
				n_steps = LEN_ENTER;
				unique case (idx_r)
					4'h0:    step = '{1'b0, ENTRY_ADDR_A, UNLOCK_D1};
					4'h1:    step = '{1'b0, ENTRY_ADDR_B, UNLOCK_D2};
					default: step = '{1'b0, ENTRY_ADDR_A, data_r};
				endcase
			end
			OP_EXIT: begin
				if (set_r == SET_EXTBLK) begin
					n_steps = LEN_EXIT_EXT;
					unique case (idx_r)
						4'h0:    step = '{1'b0, ENTRY_ADDR_A, UNLOCK_D1};
						4'h1:    step = '{1'b0, ENTRY_ADDR_B, UNLOCK_D2};
						4'h2:    step = '{1'b0, ENTRY_ADDR_A, EXIT_D1};
						default: step = '{1'b0, ZERO_ADDR, EXIT_D2};
					endcase
				end else begin
					n_steps = LEN_EXIT;
					step = '{1'b0, ZERO_ADDR,
						(idx_r == 4'h0) ? EXIT_D1 : EXIT_D2};
				end
			end
			OP_PGM: begin
				n_steps = LEN_PGM;
				if (idx_r == 4'h0) begin
					step = '{1'b0, ZERO_ADDR, PGM_PREFIX};
				end else if (set_r == SET_PASSWORD) begin
					step = '{1'b0, {21'h0, addr_r[2:0]}, data_r};
				end else begin
					step = '{1'b0, addr_r, data_r};
				end
			end
			OP_READ: begin
				n_steps = LEN_READ;
				step = '{1'b1, (set_r == SET_PASSWORD) ?
					{21'h0, addr_r[2:0]} : addr_r, 8'h00};
			end
			OP_CLEAR: begin
				n_steps = LEN_CLEAR;
				step = '{1'b0, ZERO_ADDR,
					(idx_r == 4'h0) ? CLEAR_D1 : CLEAR_D2};
			end
			OP_UNLOCK: begin
				n_steps = LEN_UNLOCK;
				unique case (idx_r)
					4'h0:    step = '{1'b0, ZERO_ADDR, PW_UNLOCK_D1};
					4'h1:    step = '{1'b0, ZERO_ADDR, PW_UNLOCK_D2};
					4'hA:    step = '{1'b0, ZERO_ADDR, PW_UNLOCK_END};
					default: step = '{1'b0, {21'h0, pw_sel},
						pw_r[8*pw_sel +: 8]};
				endcase
			end
			default: step = '0;
		endcase
	end
	// -------------------------------------------------------------
	// Sequencer: latch a request, then issue its cycles in order.
	// -------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= S_IDLE;
			op_r    <= OP_ENTER;
			idx_r   <= 4'h0;
			addr_r  <= '0;
			data_r  <= '0;
			pw_r    <= '0;
		end else begin
			unique case (state_r)
				S_IDLE: begin
					if (accept) begin
						op_r    <= i_cmd;
						addr_r  <= i_addr;
						data_r  <= i_data;
						pw_r    <= i_password;
						idx_r   <= 4'h0;
						state_r <= S_ISSUE;
					end
				end
				S_ISSUE: state_r <= S_WAIT;
				S_WAIT: begin
					if (bus_done) begin
						idx_r   <= idx_r + 4'h1;
						state_r <= last ? S_IDLE : S_ISSUE;
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end
	// Active command set follows entry and exit completions only.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			set_r <= SET_NONE;
		end else if (state_r == S_WAIT && bus_done && last) begin
			if (op_r == OP_ENTER) begin
				set_r <= sel_set;
			end else if (op_r == OP_EXIT) begin
				set_r <= SET_NONE;
			end
		end
	end
	// Answer pulses and captured read data.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_cmd_done <= 1'b0;
			o_cmd_err  <= 1'b0;
			o_rd_data  <= '0;
		end else begin
			o_cmd_done <= (state_r == S_WAIT) && bus_done && last;
			o_cmd_err  <= i_cmd_valid && o_cmd_ready && !legal;
			if (state_r == S_WAIT && bus_done && step.rd) begin
				o_rd_data <= bus_rdata;
			end
		end
	end
	// Gap timed from the final unlock write; the device drops early ones.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gap_r <= 7'h0;
		end else if (state_r == S_WAIT && bus_done && last &&
			op_r == OP_UNLOCK) begin
			gap_r <= 7'(UNLOCK_GAP_CYC);
		end else if (gap_r != 7'h0) begin
			gap_r <= gap_r - 7'h1;
		end
	end
	flash_bus_cycle u_cycle (
		.i_clk (i_clk), .i_rst_n (i_rst_n), .i_start (start),
		.i_step (step), .i_dq_in (i_dq_in), .o_done (bus_done),
		.o_rdata (bus_rdata), .o_addr (o_flash_addr),
		.o_dq_out (o_dq_out), .o_dq_oe (o_dq_oe), .o_ce_n (o_ce_n),
		.o_oe_n (o_oe_n), .o_we_n (o_we_n)
	);
	// -------------------------------------------------------------
	// Checks.
	// -------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic [3:0] starts_r;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			starts_r <= 4'h0;
		end else if (accept) begin
			starts_r <= 4'h0;
		end else if (start) begin
			starts_r <= starts_r + 4'h1;
		end
	end
	chk_entry_first_cycle: assert property (
		start && op_r == OP_ENTER && idx_r == 4'h0 |=>
		##1 o_flash_addr == 24'h000AAA && o_dq_out == 8'hAA)
		else $error("Entry did not open with AA at AAA.");
	chk_op_needs_entry: assert property (
		accept && i_cmd != OP_ENTER |-> set_r != SET_NONE)
		else $error("Operation sent outside a command set.");
	chk_exit_clears_set: assert property (
		o_cmd_done && op_r == OP_EXIT |-> set_r == SET_NONE)
		else $error("Set still active after exit.");
	chk_read_only_data: assert property (
		start && step.rd |-> op_r == OP_READ && idx_r == 4'h0)
		else $error("Read cycle outside a data read.");
	chk_pw_index_addr: assert property (
		start && op_r == OP_PGM && set_r == SET_PASSWORD && idx_r == 4'h1
		|-> step.addr[23:3] == 21'h0)
		else $error("Password byte index out of range.");
	chk_unlock_length: assert property (
		o_cmd_done && op_r == OP_UNLOCK |-> starts_r == 4'hB)
		else $error("Unlock sequence not eleven writes.");
	chk_pgm_prefix: assert property (
		start && op_r == OP_PGM && idx_r == 4'h0 |->
		step.data == 8'hA0 && !step.rd)
		else $error("Program not prefixed by A0.");
	chk_unlock_spacing: assert property (
		o_cmd_done && op_r == OP_UNLOCK |=> o_unlock_wait [*8])
		else $error("Unlock gap released too early.");
	chk_lockreg_pgm_pair: assert property (
		accept && i_cmd == OP_PGM |-> ##[4:40] start ##1 !start)
		else $error("Program data cycle not issued.");
	cov_enter_done: cover property (o_cmd_done && op_r == OP_ENTER);
	cov_unlock_done: cover property (o_cmd_done && op_r == OP_UNLOCK);
	cov_read_done: cover property (o_cmd_done && op_r == OP_READ);
	cov_refused: cover property (o_cmd_err);
endmodule : guard_cmd_host
`default_nettype wire

// file: guard_cmd_pkg.sv
`default_nettype none
package guard_cmd_pkg;

	// -------------------------------------------------------------
	// Bus widths of the byte-wide flash port.
	// -------------------------------------------------------------
	localparam int ADDR_W = 24;   // Byte address, lowest line is A-1.
	localparam int DATA_W = 8;

	// -------------------------------------------------------------
	// Command codes and fixed addresses of the protection sequences.
	// -------------------------------------------------------------
	localparam logic [23:0] ENTRY_ADDR_A = 24'h000AAA;
	localparam logic [23:0] ENTRY_ADDR_B = 24'h000555;
	localparam logic [23:0] ZERO_ADDR    = 24'h000000;
	localparam logic [7:0]  UNLOCK_D1    = 8'hAA;
	localparam logic [7:0]  UNLOCK_D2    = 8'h55;
	localparam logic [7:0]  SEL_LOCKREG  = 8'h40;
	localparam logic [7:0]  SEL_PASSWORD = 8'h60;
	localparam logic [7:0]  SEL_PERSIST  = 8'hC0;
	localparam logic [7:0]  SEL_FREEZE   = 8'h50;
	localparam logic [7:0]  SEL_VOLATILE = 8'hE0;
	localparam logic [7:0]  SEL_EXTBLK   = 8'h88;
	localparam logic [7:0]  EXIT_D1      = 8'h90;
	localparam logic [7:0]  EXIT_D2      = 8'h00;
	localparam logic [7:0]  PGM_PREFIX   = 8'hA0;
	localparam logic [7:0]  CLEAR_D1     = 8'h80;
	localparam logic [7:0]  CLEAR_D2     = 8'h30;
	localparam logic [7:0]  PW_UNLOCK_D1 = 8'h25;
	localparam logic [7:0]  PW_UNLOCK_D2 = 8'h03;
	localparam logic [7:0]  PW_UNLOCK_END = 8'h29;

	// -------------------------------------------------------------
	// Sequence lengths in bus cycles.
	// -------------------------------------------------------------
	localparam logic [3:0] LEN_ENTER      = 4'h3;
	localparam logic [3:0] LEN_EXIT       = 4'h2;
	localparam logic [3:0] LEN_EXIT_EXT   = 4'h4;
	localparam logic [3:0] LEN_PGM        = 4'h2;
	localparam logic [3:0] LEN_READ       = 4'h1;
	localparam logic [3:0] LEN_CLEAR      = 4'h2;
	localparam logic [3:0] LEN_UNLOCK     = 4'hB;
	localparam logic [3:0] UNLOCK_PW_FIRST = 4'h2;

	// -------------------------------------------------------------
	// Timing, figures in ns (clock period in ps) and derived counts at 125 MHz.
	// -------------------------------------------------------------
	localparam int CLK_PERIOD_PS   = 8000;
	localparam int T_WE_LOW_NS     = 35;    // Least write pulse width.
	localparam int T_OE_ACCESS_NS  = 70;    // Least output access time.
	localparam int T_UNLOCK_GAP_NS = 1000;  // Least gap between unlocks.
	localparam int WE_LOW_CYC =
		(T_WE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int OE_LOW_CYC =
		(T_OE_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int UNLOCK_GAP_CYC =
		(T_UNLOCK_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// -------------------------------------------------------------
	// Types.
	// -------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_ENTER  = 3'h0,
		OP_EXIT   = 3'h1,
		OP_PGM    = 3'h2,
		OP_READ   = 3'h3,
		OP_CLEAR  = 3'h4,
		OP_UNLOCK = 3'h5
	} op_t;

	typedef enum logic [2:0] {
		SET_NONE     = 3'h0,
		SET_LOCKREG  = 3'h1,
		SET_PASSWORD = 3'h2,
		SET_PERSIST  = 3'h3,
		SET_FREEZE   = 3'h4,
		SET_VOLATILE = 3'h5,
		SET_EXTBLK   = 3'h6
	} set_t;

	typedef struct packed {
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} bus_step_t;

endpackage : guard_cmd_pkg
`default_nettype wire
